// ==== verilog/tlic_top.sv ====
// Two-level interrupt controller with APB register access
// Behaviour
// [R1] High priority vectors to 0008h, low priority to 0018h when enabled.
// [R2] Eligible high request pre-empts a running low routine.
// [R3] Priority scheme active only when reset-control bit 7 set; reset zero.
// [R4] Main bit 7 enables all high-priority sources when priority active.
// [R5] Main bit 6 enables all low-priority sources when priority active.
// [R6] Flag, enable and applicable global enable together cause vectoring.
// [R7] Compatibility mode ignores priority bits, vectors all to 0008h.
// [R8] Compatibility: bit 6 gates peripheral sources, bit 7 gates all.
// [R9] Taking an interrupt clears the global enable that applies.
// [R10] No low interrupt is taken while a high routine runs.
// [R11] Core pushes return address and loads selected vector.
// [R12] Return instruction exits routine and sets applicable enable again.
// [R13] External and port-change latency three to four cycles, fixed.
// [R14] Flags set regardless of enables so software can poll.
// [R15] Port-change flag sets on upper-nibble change, sticky until cleared.
// [R16] Mismatch keeps setting the flag; port read ends the mismatch.
// [R17] Edge register bit 7 disables all pull-ups; else latch controls.
// [R18] Edge bits 6..3 select rising (1) or falling (0) per pin.
// [R19] Timer overflow sets main bit 2; bit 5 enables it.
// [R20] Pins 1..3 flags bits 0..2, enables 3..5; pin 0 in main.
// [R21] Priority bit 1 means high; positions per register layout.
// [R22] Software clears flags before enabling and before re-enabling.
// [R23] Simultaneous high and low requests vector high first.
module tlic_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [3:0]  ext_pin,
    input  wire logic [7:4]  port_pin,
    input  wire logic        port_data_read,
    input  wire logic [7:0]  port_latch,
    input  wire logic        timer_zero_overflow,
    input  wire logic        return_from_handler_instruction,
    input  wire logic        vector_ack,
    output tlic_pkg::tlic_vec_s vec_req,
    output logic [7:0]       pullup_enable,
    output logic [1:0]       service_level
);

    // ==========================================================
    // Registers
    logic [7:0] main_q, main_d;
    logic [7:0] ep_q, ep_d;
    logic [7:0] xp_q, xp_d;
    logic [7:0] rc_q, rc_d;
    logic [3:0] ext_s1_q, ext_s2_q, ext_s3_q;
    logic [7:4] port_s1_q, port_s2_q, port_last_q;
    logic       lat_ok_q;
    logic [1:0] lat_cnt_q;
    tlic_pkg::tlic_level_e lvl_q, lvl_d, prev_q;
    tlic_pkg::tlic_vec_s   vec_q;

    // ==========================================================
    // APB decode: zero wait states, unmapped addresses flag an error
    wire acc     = psel && penable;
    wire wr      = acc && pwrite;
    wire hit_m   = paddr == tlic_pkg::ADDR_MAIN;
    wire hit_e   = paddr == tlic_pkg::ADDR_EDGE_PRIO;
    wire hit_x   = paddr == tlic_pkg::ADDR_EXT_PINS;
    wire hit_r   = paddr == tlic_pkg::ADDR_RESET_CTL;
    wire hit_c   = paddr == tlic_pkg::ADDR_CORE;
    wire mapped  = hit_m | hit_e | hit_x | hit_r | hit_c;
    wire [7:0] rd_byte = hit_m ? main_q : hit_e ? ep_q : hit_x ? xp_q :
                         hit_r ? rc_q : hit_c ? {6'h00, lvl_q} : 8'h00;

    // ==========================================================
    // Edge detection on synchronised pins
    wire [3:0] ext_edge;
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_edge
            // Edge select per pin, rising when the bit is one
            assign ext_edge[g] = ep_q[tlic_pkg::EP_EDGE0 - g]   // R18
                ? (ext_s2_q[g] & ~ext_s3_q[g])
                : (~ext_s2_q[g] & ext_s3_q[g]);
        end
    endgenerate
    // Mismatch against last read value keeps setting the flag
    wire port_mis = |(port_s2_q ^ port_last_q);             // R15 R16

    // ==========================================================
    // Source views: flag, enable, priority per source
    // Order: timer, pin0, port, pin1, pin2, pin3
    wire [5:0] flg = {xp_q[2], xp_q[1], xp_q[0],
                      main_q[0], main_q[1], main_q[2]};      // R20
    wire [5:0] ena = {xp_q[5], xp_q[4], xp_q[3],
                      main_q[3], main_q[4], main_q[5]};      // R19 R20
    wire [5:0] pri = {ep_q[1], xp_q[7], xp_q[6],
                      ep_q[0], 1'b1, ep_q[2]};               // R21
    wire [5:0] act = flg & ena;                              // R6
    wire prio_on   = rc_q[tlic_pkg::RC_PRIO_EN];             // R3
    wire glob_hi   = main_q[tlic_pkg::MAIN_GLOB_HIGH];
    wire glob_lo   = main_q[tlic_pkg::MAIN_GLOB_LOW];
    // Every source here is a core source, so the peripheral gate
    // has nothing to gate in compatibility mode; only bit 7 applies.
    wire any_hi    = |(act & pri);
    wire any_lo    = |(act & ~pri);
    wire req_hi    = prio_on && glob_hi && any_hi &&
                     lvl_q != tlic_pkg::TLIC_HIGH;           // R4 R2
    wire req_lo    = prio_on && glob_lo && any_lo &&
                     lvl_q == tlic_pkg::TLIC_IDLE;           // R5 R10
    wire req_cmp   = !prio_on && glob_hi && |act &&
                     lvl_q == tlic_pkg::TLIC_IDLE;           // R7 R8
    // Requests wait out a fixed latency so it never depends on timing
    wire take_hi   = lat_ok_q && (req_hi || req_cmp);        // R23 R13
    wire take_lo   = lat_ok_q && req_lo && !req_hi;          // R23
    wire take      = (take_hi || take_lo) && !vec_q.valid;
    wire ret       = return_from_handler_instruction ||
                     (wr && hit_c && pwdata[tlic_pkg::CORE_RETURN]);

    // ==========================================================
    // Next-state of the control registers
    always_comb begin
        main_d = main_q;
        ep_d   = ep_q;
        xp_d   = xp_q;
        rc_d   = rc_q;
        lvl_d  = lvl_q;
        if (wr && hit_m) main_d = pwdata[7:0];
        if (wr && hit_e) ep_d   = pwdata[7:0];
        if (wr && hit_x) xp_d   = pwdata[7:0];
        if (wr && hit_r) rc_d   = pwdata[7:0] & 8'h80;
        // Hardware sets win over a software clear in the same cycle
        if (timer_zero_overflow) main_d[2] = 1'b1;           // R14 R19
        if (ext_edge[0]) main_d[1] = 1'b1;                   // R14
        if (port_mis) main_d[0] = 1'b1;                      // R15 R16
        xp_d[2:0] = xp_d[2:0] | ext_edge[3:1];               // R14
        // Entry clears the applicable global enable
        if (take && take_hi) begin
            main_d[tlic_pkg::MAIN_GLOB_HIGH] = 1'b0;         // R9
            lvl_d = tlic_pkg::TLIC_HIGH;
        end else if (take) begin
            main_d[tlic_pkg::MAIN_GLOB_LOW] = 1'b0;          // R9
            lvl_d = tlic_pkg::TLIC_LOW;
        end else if (ret) begin
            // Return resumes a pre-empted low routine if any
            if (lvl_q == tlic_pkg::TLIC_HIGH || !prio_on)
                main_d[tlic_pkg::MAIN_GLOB_HIGH] = 1'b1;     // R12
            else
                main_d[tlic_pkg::MAIN_GLOB_LOW] = 1'b1;      // R12
            lvl_d = (lvl_q == tlic_pkg::TLIC_HIGH) ? prev_q
                                                    : tlic_pkg::TLIC_IDLE;
        end
    end

    // ==========================================================
    // Register state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_q <= tlic_pkg::MAIN_RST;
            ep_q   <= tlic_pkg::EDGE_PRIO_RST;
            xp_q   <= tlic_pkg::EXT_PINS_RST;
            rc_q   <= tlic_pkg::RESET_CTL_RST;
            lvl_q  <= tlic_pkg::TLIC_IDLE;
            prev_q <= tlic_pkg::TLIC_IDLE;
        end else begin
            main_q <= main_d;
            ep_q   <= ep_d;
            xp_q   <= xp_d;
            rc_q   <= rc_d;
            lvl_q  <= lvl_d;
            if (take && take_hi) prev_q <= lvl_q;             // R2
        end
    end

    // ==========================================================
    // Pin synchronisers; the third stage feeds the edge detector
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_s1_q    <= 4'h0;
            ext_s2_q    <= 4'h0;
            ext_s3_q    <= 4'h0;
            port_s1_q   <= 4'h0;
            port_s2_q   <= 4'h0;
            port_last_q <= 4'h0;
        end else begin
            ext_s1_q  <= ext_pin;
            ext_s2_q  <= ext_s1_q;
            ext_s3_q  <= ext_s2_q;
            port_s1_q <= port_pin;
            port_s2_q <= port_s1_q;
            if (port_data_read) port_last_q <= port_s2_q;    // R16
        end
    end

    // ==========================================================
    // Latency counter: request must be eligible a fixed count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lat_cnt_q <= 2'h0;
            lat_ok_q  <= 1'b0;
        end else if ((req_hi || req_lo || req_cmp) && !take) begin
            if (lat_cnt_q != 2'(tlic_pkg::LAT_CYCLES - 2))
                lat_cnt_q <= lat_cnt_q + 2'h1;
            lat_ok_q <= lat_cnt_q == 2'(tlic_pkg::LAT_CYCLES - 2); // R13
        end else begin
            lat_cnt_q <= 2'h0;
            lat_ok_q  <= 1'b0;
        end
    end

    // ==========================================================
    // Vector request held until the core acknowledges the push
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vec_q <= '0;
        end else if (take) begin
            vec_q.valid <= 1'b1;                             // R11
            vec_q.high  <= take_hi;
            vec_q.addr  <= (take_hi || !prio_on) ? tlic_pkg::VEC_HIGH
                                                 : tlic_pkg::VEC_LOW; // R1 R7
        end else if (vector_ack) begin
            vec_q.valid <= 1'b0;
        end
    end

    // ==========================================================
    // Bus and pin outputs, all registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata        <= 32'h0000_0000;
            pready        <= 1'b0;
            pslverr       <= 1'b0;
            pullup_enable <= 8'h00;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata  <= {24'h000000, rd_byte};
            pullup_enable <= ep_d[tlic_pkg::EP_PULLUP_DIS] ? 8'h00
                                                           : port_latch; // R17
        end
    end

    assign vec_req       = vec_q;
    assign service_level = lvl_q;

    // ==========================================================
    // Assertions
    a_vec_addr_hi: assert property (@(posedge pclk) disable iff (!presetn)
        take && take_hi |=> vec_req.addr == tlic_pkg::VEC_HIGH) // R1
        else $error("high vector address wrong");
    a_no_low_in_hi: assert property (@(posedge pclk) disable iff (!presetn)
        lvl_q == tlic_pkg::TLIC_HIGH |-> !take_lo)         // R10
        else $error("low taken during high routine");
    a_enable_cleared: assert property (@(posedge pclk) disable iff (!presetn)
        take && take_hi |=> !main_q[7])                    // R9
        else $error("global enable not cleared");
    a_cmp_vector: assert property (@(posedge pclk) disable iff (!presetn)
        take && !prio_on |=> vec_req.addr == tlic_pkg::VEC_HIGH) // R7
        else $error("compat vector not 0008h");
    a_port_flag: assert property (@(posedge pclk) disable iff (!presetn)
        port_mis |=> main_q[0])                            // R15
        else $error("port change flag not set");
    a_tmr_flag: assert property (@(posedge pclk) disable iff (!presetn)
        timer_zero_overflow |=> main_q[2])                 // R19
        else $error("timer flag not set");
    a_latency: assert property (@(posedge pclk) disable iff (!presetn)
        take |-> $past(req_hi || req_lo || req_cmp, 2))    // R13
        else $error("vector taken too early");
    a_ret_enable: assert property (@(posedge pclk) disable iff (!presetn)
        ret && !take && lvl_q == tlic_pkg::TLIC_HIGH |=> main_q[7]) // R12
        else $error("return did not re-enable");

    // ==========================================================
    // Entry and return side: vector address, level, cleared and restored enables, order
    a_vec_addr_lo: assert property ( // R1
        @(posedge pclk) disable iff (!presetn)
        take && !take_hi |=> vec_req.addr == tlic_pkg::VEC_LOW)
        else $error("low vector address wrong");

    a_low_cleared: assert property ( // R9
        @(posedge pclk) disable iff (!presetn)
        take && !take_hi |=> !main_q[tlic_pkg::MAIN_GLOB_LOW])
        else $error("low enable not cleared");

    a_hi_level: assert property ( // R2
        @(posedge pclk) disable iff (!presetn)
        take && take_hi |=> lvl_q == tlic_pkg::TLIC_HIGH)
        else $error("high level not entered");

    a_preempt_keep: assert property ( // R2
        @(posedge pclk) disable iff (!presetn)
        take && take_hi && lvl_q == tlic_pkg::TLIC_LOW
        |=> prev_q == tlic_pkg::TLIC_LOW)
        else $error("pre-empted level lost");

    a_cmp_level: assert property ( // R7
        @(posedge pclk) disable iff (!presetn)
        take && !prio_on |=> lvl_q == tlic_pkg::TLIC_HIGH)
        else $error("compat entry level wrong");

    a_take_enabled: assert property ( // R6
        @(posedge pclk) disable iff (!presetn)
        take |-> |act)
        else $error("vector without enabled flag");

    a_vec_high: assert property ( // R23
        @(posedge pclk) disable iff (!presetn)
        take && req_hi |=> vec_req.high)
        else $error("high request not served first");

    a_vec_hold: assert property ( // R11
        @(posedge pclk) disable iff (!presetn)
        vec_req.valid && !vector_ack |=> vec_req.valid)
        else $error("vector dropped before push");

    a_vec_stable: assert property ( // R11
        @(posedge pclk) disable iff (!presetn)
        vec_req.valid && !vector_ack |=> $stable(vec_req.addr))
        else $error("vector address moved");

    a_ret_low: assert property ( // R12
        @(posedge pclk) disable iff (!presetn)
        ret && !take && prio_on && lvl_q == tlic_pkg::TLIC_LOW
        |=> main_q[tlic_pkg::MAIN_GLOB_LOW])
        else $error("low return did not re-enable");

    a_ret_level: assert property ( // R12
        @(posedge pclk) disable iff (!presetn)
        ret && !take && lvl_q == tlic_pkg::TLIC_HIGH
        |=> lvl_q == $past(prev_q))
        else $error("return level wrong");

    // ==========================================================
    // Flag, pin and register side: flags set on events, pull-ups follow, spare bits stay zero
    a_ext0_flag: assert property ( // R14
        @(posedge pclk) disable iff (!presetn)
        ext_edge[0] |=> main_q[tlic_pkg::MAIN_EXT0_FLAG])
        else $error("pin 0 flag not set");

    a_ext1_flag: assert property ( // R20
        @(posedge pclk) disable iff (!presetn)
        ext_edge[1] |=> xp_q[0])
        else $error("pin 1 flag not set");

    a_ext2_flag: assert property ( // R20
        @(posedge pclk) disable iff (!presetn)
        ext_edge[2] |=> xp_q[1])
        else $error("pin 2 flag not set");

    a_ext3_flag: assert property ( // R20
        @(posedge pclk) disable iff (!presetn)
        ext_edge[3] |=> xp_q[2])
        else $error("pin 3 flag not set");

    a_port_sticky: assert property ( // R15
        @(posedge pclk) disable iff (!presetn)
        main_q[0] && !(wr && hit_m) |=> main_q[0])
        else $error("port flag lost without clear");

    a_pullup_off: assert property ( // R17
        @(posedge pclk) disable iff (!presetn)
        ep_q[tlic_pkg::EP_PULLUP_DIS] |-> pullup_enable == 8'h00)
        else $error("pull-ups on while disabled");

    a_pullup_latch: assert property ( // R17
        @(posedge pclk) disable iff (!presetn)
        !ep_q[tlic_pkg::EP_PULLUP_DIS] |-> pullup_enable == $past(port_latch))
        else $error("pull-ups not following latch");

    a_rc_bits: assert property ( // R3
        @(posedge pclk) disable iff (!presetn)
        rc_q[6:0] == 7'h00)
        else $error("reset-control spare bits set");

endmodule

// ==== common/tlic_pkg.sv ====
// Package: register map, field positions, reset values and shared types
package tlic_pkg;

    // ==========================================================
    // Register byte addresses (APB, one word per register)
    localparam logic [11:0] ADDR_MAIN      = 12'h000;
    localparam logic [11:0] ADDR_EDGE_PRIO = 12'h004;
    localparam logic [11:0] ADDR_EXT_PINS  = 12'h008;
    localparam logic [11:0] ADDR_RESET_CTL = 12'h00c;
    localparam logic [11:0] ADDR_CORE      = 12'h010;

    // ==========================================================
    // Reset values
    localparam logic [7:0] MAIN_RST      = 8'h00;
    localparam logic [7:0] EDGE_PRIO_RST = 8'hff;
    localparam logic [7:0] EXT_PINS_RST  = 8'hc0;
    localparam logic [7:0] RESET_CTL_RST = 8'h00;

    // ==========================================================
    // Main register fields
    localparam int MAIN_GLOB_HIGH = 7;
    localparam int MAIN_GLOB_LOW  = 6;
    localparam int MAIN_TMR_EN    = 5;
    localparam int MAIN_EXT0_EN   = 4;
    localparam int MAIN_PORT_EN   = 3;
    localparam int MAIN_TMR_FLAG  = 2;
    localparam int MAIN_EXT0_FLAG = 1;
    localparam int MAIN_PORT_FLAG = 0;
    // Edge / priority register fields
    localparam int EP_PULLUP_DIS  = 7;
    localparam int EP_EDGE0       = 6;  // Edge for pin n at EP_EDGE0 - n
    localparam int EP_TMR_PRIO    = 2;
    localparam int EP_EXT3_PRIO   = 1;
    localparam int EP_PORT_PRIO   = 0;
    // External pin register fields
    localparam int XP_EXT2_PRIO   = 7;
    localparam int XP_EXT1_PRIO   = 6;
    localparam int XP_EN1         = 3;  // Enable for pin n at XP_EN1+n-1
    localparam int XP_FLAG1       = 0;  // Flag for pin n at XP_FLAG1+n-1
    // Reset-control register field
    localparam int RC_PRIO_EN     = 7;
    // Core register: bit 0 return pulse, read shows service state
    localparam int CORE_RETURN    = 0;

    // ==========================================================
    // Vectors and latency
    localparam logic [15:0] VEC_HIGH = 16'h0008;
    localparam logic [15:0] VEC_LOW  = 16'h0018;
    localparam int unsigned LAT_CYCLES = 3;

    typedef enum logic [1:0] {
        TLIC_IDLE,
        TLIC_LOW,
        TLIC_HIGH
    } tlic_level_e;

    // Vector request to the core
    typedef struct packed {
        logic        valid;
        logic [15:0] addr;
        logic        high;
    } tlic_vec_s;

endpackage

// ==== verification/tlic_core_model.sv ====
// Core-side partner model: takes vector requests after a chosen delay
module tlic_core_model (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire tlic_pkg::tlic_vec_s vec_req,
    input  wire logic [3:0]          ack_dly,
    output logic                     vector_ack
);
    logic [3:0] cnt_q;

    // ==========================================================
    // Push of the return address shown as a one-cycle ack; the ack
    // drops at once so a stale request is never taken twice
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q      <= 4'h0;
            vector_ack <= 1'b0;
        end else if (vector_ack) begin
            vector_ack <= 1'b0;
            cnt_q      <= 4'h0;
        end else if (vec_req.valid) begin
            vector_ack <= (cnt_q == ack_dly);
            cnt_q      <= cnt_q + 4'h1;
        end
    end
endmodule

// ==== verification/test_tlic_top.sv ====
// Self-checking testbench for the two-level interrupt controller
module test_tlic_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                pclk = 1'b0;
    logic                presetn = 1'b0;
    logic                psel = 1'b0;
    logic                penable = 1'b0;
    logic                pwrite = 1'b0;
    logic [11:0]         paddr = 12'h000;
    logic [31:0]         pwdata = 32'h0;
    logic [3:0]          ext_pin = 4'h0;
    logic [7:4]          port_pin = 4'h0;
    logic                port_rd = 1'b0;
    logic [7:0]          port_latch = 8'h5a;
    logic                tmr_ovf = 1'b0;
    logic                ret = 1'b0;
    logic [3:0]          ack_dly = 4'h6;
    logic [31:0]         prdata;
    logic [31:0]         rd;
    logic                pready;
    logic                pslverr;
    logic                err;
    logic                vector_ack;
    tlic_pkg::tlic_vec_s vec_req;
    logic [7:0]          pullup_enable;
    logic [1:0]          service_level;
    int                  n_mismatch = 0;
    int                  num_checks = 0;

    tlic_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_pin(ext_pin), .port_pin(port_pin), .port_data_read(port_rd),
        .port_latch(port_latch), .timer_zero_overflow(tmr_ovf),
        .return_from_handler_instruction(ret), .vector_ack(vector_ack),
        .vec_req(vec_req), .pullup_enable(pullup_enable),
        .service_level(service_level));

    tlic_core_model u_core (.pclk(pclk), .presetn(presetn),
        .vec_req(vec_req), .ack_dly(ack_dly), .vector_ack(vector_ack));

    // ==========================================================
    // Clock, verdict and helpers
    always #4 pclk = ~pclk;

    task automatic give_verdict;
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string m);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // One APB transfer; waits for pready, never a fixed count
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        chk({31'h0, pready}, 32'h1, "pready");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(rd, {24'h0, e}, "read");
    endtask

    // Waits for a vector request, judges its address, waits for the drop
    task automatic wait_vec(input logic [15:0] e, input logic h);
        int n;
        n = 0;
        while (vec_req.valid !== 1'b1 && n < 30) begin
            @(posedge pclk);
            n++;
        end
        chk({16'h0, vec_req.addr}, {16'h0, e}, "vector");
        chk({31'h0, vec_req.high}, {31'h0, h}, "vector level");
        while (vec_req.valid === 1'b1 && n < 60) begin
            @(posedge pclk);
            n++;
        end
        chk({31'h0, vec_req.valid}, 32'h0, "vector drop");
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset_values;
        rdchk(tlic_pkg::ADDR_MAIN, 8'h00);
        rdchk(tlic_pkg::ADDR_EDGE_PRIO, 8'hff);
        rdchk(tlic_pkg::ADDR_EXT_PINS, 8'hc0);
        rdchk(tlic_pkg::ADDR_RESET_CTL, 8'h00);
        apb(1'b0, 12'h020, 8'h00);
        chk({31'h0, err}, 32'h1, "unmapped error");
        chk(rd, 32'h0, "unmapped data");
    endtask

    task automatic t_edge_pullup;
        chk({24'h0, pullup_enable}, 32'h0, "pullups off");
        apb(1'b1, tlic_pkg::ADDR_EDGE_PRIO, 8'h5f);
        repeat (2) @(posedge pclk);
        chk({24'h0, pullup_enable}, 32'h5a, "pullups latch");
        ext_pin[1] <= 1'b1;
        repeat (8) @(posedge pclk);
        rdchk(tlic_pkg::ADDR_EXT_PINS, 8'hc0);
        ext_pin[1] <= 1'b0;
        repeat (8) @(posedge pclk);
        rdchk(tlic_pkg::ADDR_EXT_PINS, 8'hc1);
    endtask

    task automatic t_port_change;
        port_pin <= 4'h1;
        repeat (8) @(posedge pclk);
        rdchk(tlic_pkg::ADDR_MAIN, 8'h01);
        apb(1'b1, tlic_pkg::ADDR_MAIN, 8'h00);
        rdchk(tlic_pkg::ADDR_MAIN, 8'h01);
        @(posedge pclk) port_rd <= 1'b1;
        @(posedge pclk) port_rd <= 1'b0;
        repeat (4) @(posedge pclk);
        apb(1'b1, tlic_pkg::ADDR_MAIN, 8'h00);
        rdchk(tlic_pkg::ADDR_MAIN, 8'h00);
    endtask

    // Compatibility mode: priority bits ignored, single global enable
    task automatic t_compat;
        apb(1'b1, tlic_pkg::ADDR_MAIN, 8'h20);
        @(posedge pclk) tmr_ovf <= 1'b1;
        @(posedge pclk) tmr_ovf <= 1'b0;
        repeat (6) @(posedge pclk);
        chk({31'h0, vec_req.valid}, 32'h0, "no vector");
        rdchk(tlic_pkg::ADDR_MAIN, 8'h24);
        apb(1'b1, tlic_pkg::ADDR_MAIN, 8'ha4);
        wait_vec(16'h0008, 1'b1);
        rdchk(tlic_pkg::ADDR_MAIN, 8'h24);
        apb(1'b1, tlic_pkg::ADDR_MAIN, 8'h20);
        @(posedge pclk) ret <= 1'b1;
        @(posedge pclk) ret <= 1'b0;
        rdchk(tlic_pkg::ADDR_MAIN, 8'ha0);
    endtask

    // Priority mode: low timer, then high pin 0 pre-empts it
    task automatic t_priority;
        ack_dly <= 4'h0;
        apb(1'b1, tlic_pkg::ADDR_RESET_CTL, 8'h80);
        apb(1'b1, tlic_pkg::ADDR_EDGE_PRIO, 8'hfb);
        apb(1'b1, tlic_pkg::ADDR_MAIN, 8'h60);
        @(posedge pclk) tmr_ovf <= 1'b1;
        @(posedge pclk) tmr_ovf <= 1'b0;
        wait_vec(16'h0018, 1'b0);
        rdchk(tlic_pkg::ADDR_MAIN, 8'h24);
        apb(1'b1, tlic_pkg::ADDR_MAIN, 8'h90);
        ext_pin[0] <= 1'b1;
        wait_vec(16'h0008, 1'b1);
        chk({30'h0, service_level}, 32'h2, "high level");
        apb(1'b1, tlic_pkg::ADDR_MAIN, 8'h64);
        repeat (12) @(posedge pclk);
        chk({31'h0, vec_req.valid}, 32'h0, "low held off");
        apb(1'b1, tlic_pkg::ADDR_MAIN, 8'h00);
        @(posedge pclk) ret <= 1'b1;
        @(posedge pclk) ret <= 1'b0;
        rdchk(tlic_pkg::ADDR_MAIN, 8'h80);
        chk({30'h0, service_level}, 32'h1, "back to low");
    endtask

    // ==========================================================
    // Main sequence, with a second reset before priority mode
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_values();
        t_edge_pullup();
        t_port_change();
        t_compat();
        // Pins back to idle, else reset leaves a port mismatch behind
        @(posedge pclk) port_pin <= 4'h0;
        @(posedge pclk) presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_priority();
        give_verdict();
    end

    // Watchdog: the whole run needs well under a thousand cycles
    initial begin
        #100000;
        n_mismatch++;
        give_verdict();
    end
endmodule
